// File: logic/sfbl_master.sv
// Boot-time serial flash reader, mode 0 master.
`timescale 1ns/1ps
module sfbl_master (
    input wire logic clk_sys, // System clock, 40 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic req_valid, // Fetch request strobe
    input wire sfbl_pkg::sfbl_req_type req, // Start address and byte count
    output logic busy, // Fetch in progress
    output logic done, // One-cycle pulse at fetch end
    output logic flash_select_n, // Flash select, active low
    output logic flash_sck, // Serial clock
    output logic flash_mosi, // Serial data to flash
    input wire logic flash_miso, // Serial data from flash
    output logic wr_valid, // Byte for volatile memory valid
    input wire logic wr_ready, // Memory accepts byte
    output sfbl_pkg::sfbl_word_type wr_word // Address and byte
);
    sfbl_pkg::sfbl_state_type state;
    logic miso_meta;
    logic miso_sync;
    logic [3:0] div_cnt;
    logic [3:0] gap_cnt;
    logic [31:0] hdr_shift;
    logic [4:0] hdr_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [sfbl_pkg::len_w-1:0] remain;
    logic [sfbl_pkg::addr_w-1:0] dst_addr;
    logic tick;
    logic byte_valid;
    logic byte_ready;
    sfbl_pkg::sfbl_word_type byte_word;
    logic buf_valid;
    sfbl_pkg::sfbl_word_type buf_word;
    logic running;
    logic take;
    logic data_step;
    logic data_rise;
    logic out_load;
    logic [1:0] cap_pipe;
    logic [2:0] cap_cnt;
    logic inflight;

    // Costs a paused tick per byte under stall, but a byte is never overwritten
    function automatic logic can_start_byte(input logic slot_full, input logic pending);
        can_start_byte = !slot_full && !pending;
    endfunction

    // Flash input crosses into clk_sys
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            miso_meta <= 1'b0;
            miso_sync <= 1'b0;
        end else begin
            miso_meta <= flash_miso;
            miso_sync <= miso_meta;
        end
    end

    assign running = (state == sfbl_pkg::st_hdr) || (state == sfbl_pkg::st_data);
    assign tick = running && (div_cnt == sfbl_pkg::sck_half_max);
    assign take = (state == sfbl_pkg::st_idle) && req_valid && (req.len != '0);
    assign data_step = tick && (flash_sck || (bit_cnt != 3'h0)
                                || can_start_byte(byte_valid, inflight));
    assign data_rise = (state == sfbl_pkg::st_data) && data_step && !flash_sck;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !running || tick) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= 4'(div_cnt + 4'h1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= sfbl_pkg::st_idle;
            flash_select_n <= 1'b1;
            flash_sck <= 1'b0;
            flash_mosi <= 1'b0;
            hdr_shift <= 32'h0;
            hdr_cnt <= 5'h0;
            bit_cnt <= 3'h0;
            remain <= '0;
            gap_cnt <= 4'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state)
                sfbl_pkg::st_idle: begin
                    flash_sck <= 1'b0;
                    if (take) begin
                        flash_select_n <= 1'b0;
                        flash_mosi <= sfbl_pkg::cmd_read[7];
                        hdr_shift <= {sfbl_pkg::cmd_read[6:0], req.addr, 1'b0};
                        hdr_cnt <= 5'h0;
                        remain <= req.len;
                        busy <= 1'b1;
                        state <= sfbl_pkg::st_hdr;
                    end
                end
                sfbl_pkg::st_hdr: begin
                    if (tick) begin
                        flash_sck <= ~flash_sck;
                        if (flash_sck) begin
                            if (hdr_cnt == sfbl_pkg::hdr_last) begin
                                bit_cnt <= 3'h0;
                                state <= sfbl_pkg::st_data;
                            end else begin
                                flash_mosi <= hdr_shift[31];
                                hdr_shift <= {hdr_shift[30:0], 1'b0};
                            end
                            hdr_cnt <= 5'(hdr_cnt + 5'h1);
                        end
                    end
                end
                sfbl_pkg::st_data: begin
                    // Clock pauses low at byte start while a byte is held up
                    if (data_step) begin
                        flash_sck <= ~flash_sck;
                        if (flash_sck) begin
                            bit_cnt <= 3'(bit_cnt + 3'h1);
                            if (bit_cnt == sfbl_pkg::bit_last) begin
                                remain <= sfbl_pkg::len_w'(remain - 1'b1);
                                if (remain == sfbl_pkg::len_w'(1)) begin
                                    state <= sfbl_pkg::st_tail;
                                    gap_cnt <= 4'h0;
                                end
                            end
                        end
                    end
                end
                sfbl_pkg::st_tail: begin
                    // hold select after last falling edge
                    flash_sck <= 1'b0;
                    gap_cnt <= 4'(gap_cnt + 4'h1);
                    if (gap_cnt == sfbl_pkg::desel_max) begin
                        flash_select_n <= 1'b1;
                        gap_cnt <= 4'h0;
                        state <= sfbl_pkg::st_gap;
                    end
                end
                sfbl_pkg::st_gap: begin
                    // Let the last byte leave the capture register for the skid buffer before reporting done
                    if (can_start_byte(byte_valid, inflight)) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= sfbl_pkg::st_idle;
                    end
                end
                default: begin
                    state <= sfbl_pkg::st_idle;
                    flash_select_n <= 1'b1;
                    flash_sck <= 1'b0;
                end
            endcase
        end
    end

    // rising-edge sample, delayed to match the synchroniser
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cap_pipe <= 2'h0;
            cap_cnt <= 3'h0;
            rx_shift <= 8'h0;
            dst_addr <= '0;
            inflight <= 1'b0;
            byte_valid <= 1'b0;
            byte_word <= '0;
        end else begin
            cap_pipe <= {cap_pipe[0], data_rise};
            if (take) begin
                dst_addr <= req.addr;
            end
            if (data_rise && (bit_cnt == 3'h0)) begin
                inflight <= 1'b1;
            end
            if (byte_valid && byte_ready) begin
                byte_valid <= 1'b0;
            end
            if (cap_pipe[1]) begin
                rx_shift <= {rx_shift[6:0], miso_sync};
                cap_cnt <= 3'(cap_cnt + 3'h1);
                if (cap_cnt == sfbl_pkg::bit_last) begin
                    byte_valid <= 1'b1;
                    byte_word <= '{addr: dst_addr, data: {rx_shift[6:0], miso_sync}};
                    dst_addr <= sfbl_pkg::addr_w'(dst_addr + 1'b1);
                    inflight <= 1'b0;
                end
            end
        end
    end

    assign out_load = !wr_valid || wr_ready;

    sfbl_skid u_skid (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(byte_valid),
        .in_ready(byte_ready),
        .in_word(byte_word),
        .out_valid(buf_valid),
        .out_ready(out_load),
        .out_word(buf_word)
    );

    // Output stage registered so ports come from flip-flops
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_valid <= 1'b0;
            wr_word <= '0;
        end else if (out_load) begin
            wr_valid <= buf_valid;
            if (buf_valid) begin
                wr_word <= buf_word;
            end
        end
    end
endmodule

// File: logic/sfbl_pkg.sv
// Package for the flash boot loader: timing, commands, carriers.
package sfbl_pkg;
    // System clock and serial clock rates
    localparam int unsigned sys_clk_hz = 40000000;
    localparam int unsigned sck_hz = 12000000;
    // Half period in system cycles, rounded up: the flash is only rated to the nominal rate
    localparam int unsigned sck_half_cyc_raw = (sys_clk_hz + 2 * sck_hz - 1) / (2 * sck_hz);
    localparam int unsigned sck_half_cyc = (sck_half_cyc_raw < 1) ? 1 : sck_half_cyc_raw;
    localparam logic [3:0] sck_half_max = 4'(sck_half_cyc - 1);
    // Select-inactive guard after last falling edge
    localparam int unsigned desel_ns = 160;
    localparam int unsigned clk_ns = 25;
    localparam int unsigned desel_cyc = (desel_ns + clk_ns - 1) / clk_ns;
    localparam logic [3:0] desel_max = 4'(desel_cyc - 1);
    // Flash read command and field widths
    localparam logic [7:0] cmd_read = 8'h03;
    localparam int unsigned addr_w = 24;
    localparam int unsigned len_w = 16;
    localparam logic [2:0] bit_last = 3'h7;
    localparam logic [4:0] hdr_last = 5'h1f;
    localparam logic [1:0] buf_depth = 2'h2;

    // Boot-fetch request from the core sequencer
    typedef struct packed {
        logic [addr_w-1:0] addr;
        logic [len_w-1:0] len;
    } sfbl_req_type;

    // One byte delivered toward volatile memory
    typedef struct packed {
        logic [addr_w-1:0] addr;
        logic [7:0] data;
    } sfbl_word_type;

    typedef enum logic [4:0] {
        st_idle = 5'b00001,
        st_hdr = 5'b00010,
        st_data = 5'b00100,
        st_tail = 5'b01000,
        st_gap = 5'b10000
    } sfbl_state_type;
endpackage

// File: logic/sfbl_skid.sv
// Two-entry valid/ready buffer for fetched bytes.
`timescale 1ns/1ps
module sfbl_skid (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic in_valid, // Producer has a word
    output logic in_ready, // Room for a word
    input wire sfbl_pkg::sfbl_word_type in_word, // Word in
    output logic out_valid, // Word available
    input wire logic out_ready, // Consumer takes word
    output sfbl_pkg::sfbl_word_type out_word // Word out
);
    sfbl_pkg::sfbl_word_type mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (count != sfbl_pkg::buf_depth);
    assign out_valid = (count != 2'h0);
    assign out_word = mem[rd_ptr];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_word;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= 2'(count + {1'b0, push} - {1'b0, pop});
        end
    end
endmodule

// File: tb/sfbl_checker_properties.sv
// Link and memory-side properties of the flash reader.
`timescale 1ns/1ps
module sfbl_checker (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Reset, active low
    input wire logic req_valid, // Request strobe
    input wire sfbl_pkg::sfbl_req_type req, // Request
    input wire logic busy, // Busy
    input wire logic done, // Done pulse
    input wire logic flash_select_n, // Select
    input wire logic flash_sck, // Serial clock
    input wire logic flash_mosi, // Serial out
    input wire logic wr_valid, // Byte valid
    input wire logic wr_ready, // Byte taken
    input wire sfbl_pkg::sfbl_word_type wr_word // Byte
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [3:0] gap;
    // Low cycles since the last serial clock fall
    always_ff @(posedge clk_sys) begin
        if (!rst_n || flash_sck) gap <= 4'h0;
        else if (gap != 4'hf) gap <= gap + 4'h1;
    end
    property p_start;
        req_valid && !busy && req.len != 16'h0000 |=> !flash_select_n && busy;
    endproperty
    a_start: assert property (p_start) else $error("fetch not started");
    property p_sel_busy;
        !flash_select_n |-> busy;
    endproperty
    a_sel_busy: assert property (p_sel_busy) else $error("select low while idle");
    property p_first_bit;
        $fell(flash_select_n) |-> flash_mosi == sfbl_pkg::cmd_read[7] && !flash_sck;
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("first bit late");
    // Select to first rise is one 50 ns half period
    property p_first_rise;
        $fell(flash_select_n) |=> !flash_sck ##1 flash_sck;
    endproperty
    a_first_rise: assert property (p_first_rise) else $error("no first rise");
    property p_mosi_fall;
        !flash_select_n && $past(!flash_select_n) && $changed(flash_mosi) |-> $fell(flash_sck);
    endproperty
    a_mosi_fall: assert property (p_mosi_fall) else $error("data moved off fall");
    property p_sck_idle;
        flash_select_n |-> !flash_sck;
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("clock not idle low");
    // High half is two system cycles
    property p_sck_half;
        $rose(flash_sck) |=> flash_sck ##1 !flash_sck;
    endproperty
    a_sck_half: assert property (p_sck_half) else $error("clock high time wrong");
    property p_guard;
        $rose(flash_select_n) |-> gap == 4'h7;
    endproperty
    a_guard: assert property (p_guard) else $error("select release time wrong");
    property p_wr_hold;
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_word);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("byte dropped");
    property p_done_pulse;
        done |=> !done && !busy;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
    c_fetch: cover property ($fell(flash_select_n));
    c_pause: cover property ((!flash_select_n && !flash_sck && !wr_ready) [*8]);
    c_stall: cover property (wr_valid && !wr_ready ##1 wr_valid && !wr_ready);
    c_done: cover property (done);
endmodule
bind sfbl_master sfbl_checker i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
    .req(req), .busy(busy), .done(done), .flash_select_n(flash_select_n),
    .flash_sck(flash_sck), .flash_mosi(flash_mosi), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_word(wr_word));

// File: tb/sfbl_flash_model.sv
// Behavioural serial flash answering plain reads.
`timescale 1ns/1ps
module sfbl_flash_model (
    input wire logic sel_n, // Select, active low
    input wire logic sck, // Serial clock
    input wire logic mosi, // Data from master
    output logic miso, // Data to master
    output logic [31:0] hdr // Command and address seen
);
    int cnt = 0;
    logic [7:0] sh = 8'h00;
    initial miso = 1'b0;
    initial hdr = 32'h00000000;
    always @(posedge sck) begin
        if (cnt < 32) hdr = {hdr[30:0], mosi};
        cnt = cnt + 1;
    end
    always @(negedge sck) begin
        if (cnt >= 32 && cnt % 8 == 0) sh = (hdr[7:0] + 8'((cnt - 32) / 8)) ^ 8'ha5;
        if (cnt >= 32) begin
            miso = sh[7];
            sh = {sh[6:0], 1'b0};
        end
    end
    // Released line shows no stale bit
    always @(posedge sel_n) begin
        cnt = 0;
        miso = ~miso;
    end
endmodule

// File: tb/test_spi_flash_boot_loader.sv
// Self-checking bench for the flash boot loader.
`timescale 1ns/1ps
module test_spi_flash_boot_loader;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    sfbl_pkg::sfbl_req_type req = '0;
    logic wr_ready = 1'b1;
    logic busy, done, sel_n, sck, mosi, miso, wr_valid;
    sfbl_pkg::sfbl_word_type wr_word;
    sfbl_pkg::sfbl_word_type q[$];
    logic [31:0] hdr;
    int error_cnt = 0;
    int tests_run = 0;
    sfbl_master i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .busy(busy), .done(done), .flash_select_n(sel_n), .flash_sck(sck), .flash_mosi(mosi),
        .flash_miso(miso), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word));
    sfbl_flash_model i_flash (.sel_n(sel_n), .sck(sck), .mosi(mosi), .miso(miso), .hdr(hdr));
    initial forever #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (wr_valid === 1'b1 && wr_ready === 1'b1) q.push_back(wr_word);
    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_reset();
        @(negedge clk_sys);
        chk("select", sel_n, 1'b1);
        chk("sck", sck, 1'b0);
        chk("busy", busy, 1'b0);
        chk("wr_valid", wr_valid, 1'b0);
    endtask
    // Zero length is ignored
    task automatic t_zero();
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{addr: 24'h000100, len: 16'h0000};
        @(posedge clk_sys);
        req_valid <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("zero busy", busy, 1'b0);
        chk("zero select", sel_n, 1'b1);
    endtask
    // Fetch with a refused mid-run request and an optional stall
    task automatic fetch(input logic [23:0] a, input logic [15:0] n, input int stall);
        int k;
        logic [23:0] ad;
        q.delete();
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{addr: a, len: n};
        wr_ready <= (stall == 0);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        repeat (8) @(posedge clk_sys);
        req_valid <= 1'b1;
        req.addr <= ~a;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        repeat (stall) @(posedge clk_sys);
        if (stall > 0) begin
            @(negedge clk_sys);
            // Held-up bytes must pause the link, not drop data
            chk("pause sck", sck, 1'b0);
            chk("pause select", sel_n, 1'b0);
            chk("pause hold", wr_valid, 1'b1);
            @(posedge clk_sys);
        end
        wr_ready <= 1'b1;
        k = 0;
        while (done !== 1'b1 && k < 5000) begin
            @(negedge clk_sys);
            k++;
        end
        chk("done", done, 1'b1);
        repeat (6) @(negedge clk_sys);
        chk("header", hdr, {sfbl_pkg::cmd_read, a});
        chk("count", 40'(q.size()), 40'(n));
        for (k = 0; k < q.size(); k++) begin
            ad = a + 24'(k);
            chk("word", q[k], {ad, ad[7:0] ^ 8'ha5});
        end
        chk("idle select", sel_n, 1'b1);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_zero();
        // read crosses a 4 KB sector boundary
        fetch(24'h000ffe, 16'h0003, 0);
        // Long stall fills every slot and pauses the link
        fetch(24'h123456, 16'h0006, 400);
        fetch(24'hfffff0, 16'h0001, 0);
        give_verdict();
    end
endmodule
